/* design/address_table_unit.sv */
`timescale 1ns/1ns
module address_table_unit
  import mac_table_pkg::*;
#(
  parameter int NUM_PORTS = 6
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_PORTS-1:0] req_valid_i,
  input wire logic [NUM_PORTS-1:0][mac_table_pkg::ADDR_W-1:0] req_da_i,
  input wire logic [NUM_PORTS-1:0][mac_table_pkg::ADDR_W-1:0] req_sa_i,
  output logic [NUM_PORTS-1:0] req_ready_o,
  input wire logic [NUM_PORTS-1:0][mac_table_pkg::DB_W-1:0] database_select_i,
  input wire logic [NUM_PORTS-1:0][1:0] port_forward_state_i,
  input wire logic [NUM_PORTS-1:0][NUM_PORTS-1:0] port_assoc_mask_i,
  input wire logic [NUM_PORTS-1:0][NUM_PORTS-1:0] port_egress_mask_i,
  input wire logic [NUM_PORTS-1:0] link_up_i,
  input wire logic learn_global_off_i,
  input wire logic [1:0] table_size_sel_i,
  input wire logic [mac_table_pkg::AGE_CODE_W-1:0] age_time_i,
  output logic result_valid_o,
  output logic result_hit_o,
  output logic [$clog2(NUM_PORTS)-1:0] result_port_o,
  output logic [NUM_PORTS-1:0] result_mask_o,
  output logic table_full_event_o,
  output logic switch_soft_reset_o,
  output logic table_busy_o,
  output logic aging_enabled_o,
  output logic [mac_table_pkg::AGE_SEC_W-1:0] age_period_sec_o
);
  import mac_table_pkg::*;

  localparam int PORT_W = $clog2(NUM_PORTS);

  // ==========================================================================
  // Elaboration checks
  if (NUM_PORTS < 2 || NUM_PORTS > MASK_W)
  begin : g_bad_ports
    $error("NUM_PORTS must lie between 2 and the entry mask width");
  end
  // Serving every port once must fit in one minimum frame time.
  if (NUM_PORTS * SERVICE_CYCLES > FRAME_CYCLES)
  begin : g_bad_budget
    $error("lookup service time exceeds one minimum frame time");
  end

  typedef enum logic [2:0] {S_CLEAR, S_IDLE, S_DA_READ, S_DA_EVAL, S_SA_EVAL} state_t;

  // ==========================================================================
  // Reset and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [NUM_PORTS-1:0] link_meta_reg;
  logic [NUM_PORTS-1:0] link_up_reg;

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_meta_reg <= '0;
      link_up_reg <= '0;
    end
    else
    begin
      link_meta_reg <= link_up_i;
      link_up_reg <= link_meta_reg;
    end
  end

  // ==========================================================================
  // State
  state_t state_reg;
  state_t state_next;
  bin_t table_mem [MAX_BINS];
  bin_t bin_reg;
  logic [1:0] size_reg;
  logic size_change;
  logic [BIN_IDX_W-1:0] clear_idx_reg;
  logic [PORT_W-1:0] rr_ptr_reg;
  logic [PORT_W-1:0] port_reg;
  logic [ADDR_W-1:0] da_reg;
  logic [ADDR_W-1:0] sa_reg;
  logic [DB_W-1:0] db_reg;
  logic grant_any;
  logic [PORT_W-1:0] grant_port;
  logic [NUM_PORTS-1:0] flood_mask;
  logic learn_ok;
  logic learn_write;
  logic [WAY_W-1:0] learn_way;
  logic [BIN_IDX_W-1:0] last_bin;
  entry_t learn_entry;

  bin_match_if match ();

  bin_compare u_cmp (
    .m(match.cmp)
  );

  // Invalid size codes fall back to the largest table.
  function automatic logic [1:0] size_legal(input logic [1:0] sel);
    size_legal = (sel == SIZE_256 || sel == SIZE_512) ? sel : SIZE_1024;
  endfunction

  assign size_change = (size_legal(table_size_sel_i) != size_reg);
  // The sweep always covers every bin, whatever table size is selected.
  assign last_bin = BIN_IDX_W'(MAX_BINS - 1);

  // ==========================================================================
  // Round-robin arbiter
  always_comb
  begin
    logic [PORT_W-1:0] idx;
    idx = '0;
    grant_any = 1'b0;
    grant_port = '0;
    for (int k = NUM_PORTS - 1; k >= 0; k--)
    begin
      idx = PORT_W'((int'(rr_ptr_reg) + k) % NUM_PORTS);
      if (req_valid_i[idx])
      begin
        grant_any = 1'b1;
        grant_port = idx;
      end
    end
  end

  always_comb
  begin
    req_ready_o = '0;
    if (state_reg == S_IDLE && grant_any && !size_change)
      req_ready_o[grant_port] = 1'b1;
  end

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_CLEAR: if (clear_idx_reg == last_bin) state_next = S_IDLE;
      S_IDLE:
      begin
        if (size_change)
          state_next = S_CLEAR;
        else if (grant_any)
          state_next = S_DA_READ;
      end
      S_DA_READ: state_next = S_DA_EVAL;
      S_DA_EVAL: state_next = S_SA_EVAL;
      S_SA_EVAL: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= S_CLEAR;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      size_reg <= SIZE_RESET;
      switch_soft_reset_o <= 1'b0;
      clear_idx_reg <= '0;
    end
    else
    begin
      switch_soft_reset_o <= (state_reg == S_IDLE) && size_change;
      if (state_reg == S_IDLE && size_change)
        size_reg <= size_legal(table_size_sel_i);
      clear_idx_reg <= (state_reg == S_CLEAR) ? clear_idx_reg + 1'b1 : '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rr_ptr_reg <= '0;
      port_reg <= '0;
      da_reg <= '0;
      sa_reg <= '0;
      db_reg <= '0;
    end
    else if (state_reg == S_IDLE && grant_any && !size_change)
    begin
      rr_ptr_reg <= (int'(grant_port) == NUM_PORTS - 1) ? '0 : grant_port + 1'b1;
      port_reg <= grant_port;
      da_reg <= req_da_i[grant_port];
      sa_reg <= req_sa_i[grant_port];
      db_reg <= database_select_i[grant_port];
    end
  end

  // ==========================================================================
  // Table storage: clear sweep and learning share one write port.
  assign match.bin = bin_reg;
  assign match.addr = (state_reg == S_SA_EVAL) ? sa_reg : da_reg;
  assign match.db = db_reg;

  always_ff @(posedge ref_clk_i)
  begin
    if (state_reg == S_DA_READ)
      bin_reg <= table_mem[bin_hash(da_reg, db_reg, size_reg)];
    else if (state_reg == S_DA_EVAL)
      bin_reg <= table_mem[bin_hash(sa_reg, db_reg, size_reg)];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (state_reg == S_CLEAR)
      table_mem[clear_idx_reg] <= '0;
    else if (learn_write)
      table_mem[bin_hash(sa_reg, db_reg, size_reg)][learn_way] <= learn_entry;
  end

  // ==========================================================================
  // Learning decision
  always_comb
  begin
    learn_ok = !learn_global_off_i;
    if (port_forward_state_i[port_reg] == PS_DISABLED
        || port_forward_state_i[port_reg] == PS_BLOCKING
        || port_assoc_mask_i[port_reg] == '0)
      learn_ok = 1'b0;
    if (sa_reg[MCAST_BIT])
      learn_ok = 1'b0;
  end

  // The stored database and fresh age make a new or moved station current.
  assign learn_entry = {2'h0, db_reg, MASK_W'(port_assoc_mask_i[port_reg]), ST_FRESH,
                        sa_reg};

  always_comb
  begin
    learn_write = 1'b0;
    learn_way = '0;
    if (state_reg == S_SA_EVAL && learn_ok)
    begin
      // Static entries are not overwritten by traffic.
      if (match.hit)
      begin
        learn_write = !match.hit_locked;
        learn_way = match.hit_way;
      end
      else if (match.free_ok)
      begin
        learn_write = 1'b1;
        learn_way = match.free_way;
      end
      else if (match.victim_ok)
      begin
        learn_write = 1'b1;
        learn_way = match.victim_way;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      table_full_event_o <= 1'b0;
    else
      table_full_event_o <= state_reg == S_SA_EVAL && learn_ok && !match.hit
                            && !match.free_ok && !match.victim_ok;
  end

  // ==========================================================================
  // Destination result
  always_comb
  begin
    flood_mask = '0;
    for (int p = 0; p < NUM_PORTS; p++)
      flood_mask[p] = link_up_reg[p] && port_forward_state_i[p] != PS_DISABLED
                      && PORT_W'(p) != port_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_valid_o <= 1'b0;
      result_hit_o <= 1'b0;
      result_port_o <= '0;
      result_mask_o <= '0;
    end
    else
    begin
      result_valid_o <= (state_reg == S_DA_EVAL);
      if (state_reg == S_DA_EVAL)
      begin
        result_hit_o <= match.hit;
        result_port_o <= port_reg;
        if (match.hit)
          result_mask_o <= match.bin[match.hit_way][MASK_LSB +: NUM_PORTS];
        else
          result_mask_o <= port_egress_mask_i[port_reg] & flood_mask;
      end
    end
  end

  // ==========================================================================
  // Status and aging period for the sweep logic outside this block.
  assign table_busy_o = (state_reg == S_CLEAR);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aging_enabled_o <= 1'b0;
      age_period_sec_o <= '0;
    end
    else
    begin
      aging_enabled_o <= (age_time_i != '0);
      age_period_sec_o <= AGE_SEC_W'(age_time_i * AGE_STEP_SEC);
    end
  end

endmodule // address_table_unit

/* pkg/mac_table_pkg.sv */
package mac_table_pkg;

  // ==========================================================================
  // Entry layout
  localparam int ADDR_W = 48;
  localparam int ENTRY_W = 64;
  localparam int WAYS = 4;
  localparam int WAY_W = 2;
  localparam int DB_W = 4;
  localparam int MASK_W = 6;
  localparam int STATE_LSB = 48;
  localparam int STATE_W = 4;
  localparam int MASK_LSB = 52;
  localparam int DB_LSB = 58;
  localparam int MCAST_BIT = 40;
  localparam logic [STATE_W-1:0] ST_EMPTY = 4'h0;
  localparam logic [STATE_W-1:0] ST_FRESH = 4'hE;
  localparam logic [STATE_W-1:0] ST_LOCKED = 4'hF;

  // ==========================================================================
  // Table size and port state codes
  localparam int MAX_BINS = 256;
  localparam int BIN_IDX_W = 8;
  localparam logic [1:0] SIZE_256 = 2'h0;
  localparam logic [1:0] SIZE_512 = 2'h1;
  localparam logic [1:0] SIZE_1024 = 2'h2;
  localparam logic [1:0] SIZE_RESET = SIZE_1024;
  localparam logic [1:0] PS_DISABLED = 2'h0;
  localparam logic [1:0] PS_BLOCKING = 2'h1;

  // ==========================================================================
  // Aging and timing
  localparam int AGE_STEP_SEC = 16;
  localparam int AGE_CODE_W = 8;
  localparam int AGE_SEC_W = 12;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_FRAME_BYTES = 64;
  localparam int BYTE_TIME_NS = 80;
  localparam int FRAME_CYCLES = MIN_FRAME_BYTES * BYTE_TIME_NS / CLK_PERIOD_NS;
  localparam int SERVICE_CYCLES = 4;

  typedef logic [ENTRY_W-1:0] entry_t;
  typedef entry_t [WAYS-1:0] bin_t;

  // Byte fold keeps every address bit in the index for SIZE_1024 only; database mixed in so equal
  // addresses of different databases tend to spread.
  function automatic logic [BIN_IDX_W-1:0] bin_hash(input logic [ADDR_W-1:0] addr,
                                                    input logic [DB_W-1:0] db,
                                                    input logic [1:0] size_sel);
    logic [BIN_IDX_W-1:0] fold;
    fold = addr[7:0] ^ addr[15:8] ^ addr[23:16] ^ addr[31:24] ^ addr[39:32]
         ^ addr[47:40] ^ {4'h0, db};
    unique case (size_sel)
      SIZE_256: bin_hash = fold & 8'h3F;
      SIZE_512: bin_hash = fold & 8'h7F;
      default: bin_hash = fold;
    endcase
  endfunction

endpackage

/* pkg/bin_match_if.sv */
`timescale 1ns/1ns
interface bin_match_if;
  import mac_table_pkg::*;
  bin_t bin;
  logic [ADDR_W-1:0] addr;
  logic [DB_W-1:0] db;
  logic hit;
  logic hit_locked;
  logic [WAY_W-1:0] hit_way;
  logic free_ok;
  logic [WAY_W-1:0] free_way;
  logic victim_ok;
  logic [WAY_W-1:0] victim_way;
  modport cmp (input bin, addr, db,
               output hit, hit_locked, hit_way, free_ok, free_way, victim_ok, victim_way);
  modport user (output bin, addr, db,
                input hit, hit_locked, hit_way, free_ok, free_way, victim_ok, victim_way);
endinterface

/* design/bin_compare.sv */
`timescale 1ns/1ns
module bin_compare
  import mac_table_pkg::*;
(
  bin_match_if.cmp m
);

  always_comb
  begin
    logic valid;
    logic locked;
    logic [STATE_W-1:0] st;
    logic [STATE_W-1:0] best;
    valid = 1'b0;
    locked = 1'b0;
    st = ST_EMPTY;
    best = ST_LOCKED;
    m.hit = 1'b0;
    m.hit_locked = 1'b0;
    m.hit_way = '0;
    m.free_ok = 1'b0;
    m.free_way = '0;
    m.victim_ok = 1'b0;
    m.victim_way = '0;
    for (int w = 0; w < WAYS; w++)
    begin
      st = m.bin[w][STATE_LSB +: STATE_W];
      valid = (st != ST_EMPTY);
      // Multicast entries only come from loading and are always static.
      locked = m.bin[w][MCAST_BIT] ? valid : (st == ST_LOCKED);
      if (valid && !m.hit && m.bin[w][ADDR_W-1:0] == m.addr
          && m.bin[w][DB_LSB +: DB_W] == m.db)
      begin
        m.hit = 1'b1;
        m.hit_locked = locked;
        m.hit_way = WAY_W'(w);
      end
      if (!valid && !m.free_ok)
      begin
        m.free_ok = 1'b1;
        m.free_way = WAY_W'(w);
      end
      // Strictly lower age wins, so equal ages keep the first unlocked way.
      if (!locked && (!m.victim_ok || st < best))
      begin
        m.victim_ok = 1'b1;
        m.victim_way = WAY_W'(w);
        best = st;
      end
    end
  end

endmodule // bin_compare

/* sim/address_table_unit_assertions.sv */
`timescale 1ns/1ns
module address_table_unit_assertions
  import mac_table_pkg::*;
#(
  parameter int NUM_PORTS = 6
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_PORTS-1:0] req_valid_i,
  input wire logic [NUM_PORTS-1:0] req_ready_o,
  input wire logic [NUM_PORTS-1:0][NUM_PORTS-1:0] port_egress_mask_i,
  input wire logic result_valid_o,
  input wire logic result_hit_o,
  input wire logic [$clog2(NUM_PORTS)-1:0] result_port_o,
  input wire logic [NUM_PORTS-1:0] result_mask_o,
  input wire logic table_full_event_o,
  input wire logic switch_soft_reset_o,
  input wire logic table_busy_o,
  input wire logic aging_enabled_o,
  input wire logic [mac_table_pkg::AGE_SEC_W-1:0] age_period_sec_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========
  // Grant and result timing
  property p_grant_onehot; $onehot0(req_ready_o); endproperty
  a_grant_onehot: assert property (p_grant_onehot) else $error("grant not one-hot");
  property p_grant_valid; (req_ready_o & ~req_valid_i) == '0; endproperty
  a_grant_valid: assert property (p_grant_valid) else $error("grant without request");
  property p_grant_gap; |req_ready_o |=> (req_ready_o == '0) [*3]; endproperty
  a_grant_gap: assert property (p_grant_gap) else $error("grant during service");
  property p_result_time; |req_ready_o |-> ##3 result_valid_o; endproperty
  a_result_time: assert property (p_result_time) else $error("result late");
  property p_result_port;
    result_valid_o |-> $past(req_ready_o, 3) == (NUM_PORTS'(1) << result_port_o);
  endproperty
  a_result_port: assert property (p_result_port) else $error("result port wrong");
  // ==========
  // Miss mask
  property p_miss_ingress;
    result_valid_o && !result_hit_o |-> !result_mask_o[result_port_o];
  endproperty
  a_miss_ingress: assert property (p_miss_ingress) else $error("flood hits ingress");
  property p_miss_egress;
    result_valid_o && !result_hit_o |->
      (result_mask_o & ~port_egress_mask_i[result_port_o]) == '0;
  endproperty
  a_miss_egress: assert property (p_miss_egress) else $error("flood beyond egress");
  // ==========
  // Clear, events, aging
  property p_busy_no_grant; table_busy_o |-> req_ready_o == '0; endproperty
  a_busy_no_grant: assert property (p_busy_no_grant) else $error("grant while busy");
  property p_soft_reset;
    switch_soft_reset_o |-> table_busy_o ##1 (!switch_soft_reset_o && table_busy_o);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset shape");
  property p_full_pulse;
    table_full_event_o |-> $past(result_valid_o) && !$past(table_full_event_o);
  endproperty
  a_full_pulse: assert property (p_full_pulse) else $error("full event timing");
  property p_age_en; aging_enabled_o == (age_period_sec_o != '0); endproperty
  a_age_en: assert property (p_age_en) else $error("aging enable mismatch");
  c_hit: cover property (result_valid_o && result_hit_o);
  c_miss: cover property (result_valid_o && !result_hit_o);
  c_soft: cover property (switch_soft_reset_o);
  c_contend: cover property ($countones(req_valid_i) > 1 && |req_ready_o);
endmodule // address_table_unit_assertions

bind address_table_unit address_table_unit_assertions #(.NUM_PORTS(NUM_PORTS)) chk_inst (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o), .port_egress_mask_i(port_egress_mask_i),
  .result_valid_o(result_valid_o), .result_hit_o(result_hit_o),
  .result_port_o(result_port_o), .result_mask_o(result_mask_o),
  .table_full_event_o(table_full_event_o), .switch_soft_reset_o(switch_soft_reset_o),
  .table_busy_o(table_busy_o), .aging_enabled_o(aging_enabled_o),
  .age_period_sec_o(age_period_sec_o)
);

/* sim/port_requester.sv */
`timescale 1ns/1ns
module port_requester
#(
  parameter int NUM_PORTS = 6
)
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_PORTS-1:0] load_i,
  input wire logic [47:0] da_i,
  input wire logic [47:0] sa_i,
  input wire logic [NUM_PORTS-1:0] req_ready_i,
  output logic [NUM_PORTS-1:0] req_valid_o,
  output logic [NUM_PORTS-1:0][47:0] req_da_o,
  output logic [NUM_PORTS-1:0][47:0] req_sa_o
);
  // Each port holds its request until granted; afterwards the address lines
  // flip so a design that samples them late sees garbage, not a stale match.
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_valid_o <= '0;
      req_da_o <= '0;
      req_sa_o <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (load_i[p])
        begin
          req_valid_o[p] <= 1'b1;
          req_da_o[p] <= da_i;
          req_sa_o[p] <= sa_i;
        end
        else if (req_ready_i[p] && req_valid_o[p])
        begin
          req_valid_o[p] <= 1'b0;
          req_da_o[p] <= ~req_da_o[p];
          req_sa_o[p] <= ~req_sa_o[p];
        end
      end
    end
  end
endmodule // port_requester

/* sim/tb_address_table_unit.sv */
`timescale 1ns/1ns
module tb_address_table_unit;
  import mac_table_pkg::*;
  localparam int N = 4;
  localparam logic [47:0] A = 48'h0000_0000_1234;
  localparam logic [47:0] B = 48'h0000_0000_5678;
  localparam logic [47:0] M = 48'h0100_5E00_0001;
  localparam logic [47:0] NL = 48'h0100_0000_0000;
  localparam logic [47:0] C = 48'h0000_0000_C000;
  logic ref_clk_i = 0, reset_n_i = 0, learn_off = 0, rv, rh, full, swr, busy, age_en;
  logic [N-1:0] load = '0, req_valid, req_ready, link, rmask, seen;
  logic [47:0] ld_da = '0, ld_sa = '0;
  logic [N-1:0][47:0] req_da, req_sa;
  logic [N-1:0][DB_W-1:0] db;
  logic [N-1:0][1:0] pst;
  logic [N-1:0][N-1:0] assoc, egress;
  logic [1:0] size_sel = SIZE_1024, rport;
  logic [AGE_CODE_W-1:0] age = '0;
  logic [AGE_SEC_W-1:0] age_sec;
  logic [7:0] ages [3] = '{8'h00, 8'h01, 8'hFF};
  int err_count = 0, total_checks = 0, i, k;

  initial forever #2 ref_clk_i = ~ref_clk_i;

  port_requester #(.NUM_PORTS(N)) port_requester_inst (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .load_i(load), .da_i(ld_da), .sa_i(ld_sa),
    .req_ready_i(req_ready), .req_valid_o(req_valid), .req_da_o(req_da), .req_sa_o(req_sa));

  address_table_unit #(.NUM_PORTS(N)) address_table_unit_inst (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .req_valid_i(req_valid), .req_da_i(req_da), .req_sa_i(req_sa),
    .req_ready_o(req_ready), .database_select_i(db), .port_forward_state_i(pst),
    .port_assoc_mask_i(assoc), .port_egress_mask_i(egress), .link_up_i(link),
    .learn_global_off_i(learn_off), .table_size_sel_i(size_sel), .age_time_i(age),
    .result_valid_o(rv), .result_hit_o(rh), .result_port_o(rport), .result_mask_o(rmask),
    .table_full_event_o(full), .switch_soft_reset_o(swr), .table_busy_o(busy),
    .aging_enabled_o(age_en), .age_period_sec_o(age_sec));

  // ==========
  // Helpers
  function automatic logic [N-1:0] flood(int p);
    logic [N-1:0] m;
    m = egress[p] & link;
    for (int j = 0; j < N; j++)
      if (pst[j] == PS_DISABLED) m[j] = 1'b0;
    m[p] = 1'b0;
    return m;
  endfunction

  task automatic check(logic [63:0] got, logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic look(int p, logic [47:0] da, logic [47:0] sa, logic hit, logic [N-1:0] mask);
    @(posedge ref_clk_i); #1;
    load[p] = 1'b1;
    ld_da = da;
    ld_sa = sa;
    @(posedge ref_clk_i); #1;
    load = '0;
    for (i = 0; i < 40 && rv !== 1'b1; i++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    check(rv, 1);
    check(rh, hit);
    check(rport, p);
    check(rmask, mask);
    // Learning is decided at the next edge, so port settings must hold until it has passed.
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wait_idle;
    for (i = 0; i < 600 && busy !== 1'b0; i++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    check(busy, 0);
  endtask

  task automatic conclude;
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========
  // Watchdog: the whole sequence needs well under 5000 cycles.
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    conclude();
  end

  // ==========
  // Tests
  initial
  begin
    db = {N{4'h1}};
    pst = {PS_DISABLED, 2'h2, 2'h3, 2'h3};
    link = 4'b1011;
    assoc = {4'b1000, 4'b0110, 4'b0000, 4'b0001};
    egress = {4'hF, 4'hF, 4'b1101, 4'hF};
    repeat (4) @(posedge ref_clk_i);
    #1 reset_n_i = 1;
    wait_idle();
    look(0, A, A, 0, flood(0));
    look(1, A, NL, 1, 4'b0001);
    db[1] = 4'h2;
    look(1, A, NL, 0, flood(1));
    db[1] = 4'h1;
    look(2, B, A, 0, flood(2));
    look(1, A, NL, 1, 4'b0110);
    db[0] = 4'h2;
    db[1] = 4'h2;
    look(0, NL, A, 0, flood(0));
    look(1, A, NL, 1, 4'b0001);
    db = {N{4'h1}};
    look(1, A, NL, 1, 4'b0110);
    look(0, B, M, 0, flood(0));
    look(1, M, NL, 0, flood(1));
    for (k = 0; k < 4; k++)
    begin
      learn_off = (k == 0);
      if (k > 1) pst[3] = 2'(k - 2);
      look((k == 0) ? 0 : (k == 1) ? 1 : 3, NL, C + k, 0, flood((k < 2) ? k : 3));
      learn_off = 0;
      pst[3] = PS_DISABLED;
      look(0, C + k, NL, 0, flood(0));
    end
    for (k = 1; k < 5; k++) look(0, NL, {32'h0, 8'(k), 8'(k)}, 0, flood(0));
    for (k = 1; k < 5; k++) look(1, {32'h0, 8'(k), 8'(k)}, NL, 1, 4'b0001);
    look(2, NL, 48'h0505, 0, flood(2));
    look(1, 48'h0101, NL, 0, flood(1));
    look(1, 48'h0505, NL, 1, 4'b0110);
    look(1, 48'h0202, NL, 1, 4'b0001);
    @(posedge ref_clk_i); #1;
    load = '1;
    ld_da = A;
    ld_sa = NL;
    @(posedge ref_clk_i); #1;
    load = '0;
    seen = '0;
    for (i = 0; i < FRAME_CYCLES && seen !== '1; i++)
    begin
      @(posedge ref_clk_i); #1;
      if (rv === 1'b1) seen[rport] = 1'b1;
    end
    check(seen, 4'hF);
    for (k = 0; k < 3; k++)
    begin
      age = ages[k];
      repeat (2) @(posedge ref_clk_i);
      #1;
      check(age_en, ages[k] != 0);
      check(age_sec, {ages[k], 4'h0});
    end
    for (k = 0; k < 3; k++)
    begin
      size_sel = 2'(k);
      for (i = 0; i < 8 && swr !== 1'b1; i++) begin @(posedge ref_clk_i); #1; end
      check(swr, 1);
      wait_idle();
      look(1, A, NL, 0, flood(1));
      look(0, NL, A, 0, flood(0));
      look(1, A, NL, 1, 4'b0001);
    end
    conclude();
  end
endmodule // tb_address_table_unit
